// ==== rtl/byte_alu_top.sv ====
// Top of the byte logic, shift and bit datapath with register file, CONDITION_CODE_REGISTER and memory sequencing
module byte_alu_top (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic req_valid,
   input wire alu_pkg::alu_req_s req,
   output logic req_ready_r,
   output logic done_r,
   output logic refused_r,
   output logic mem_rd_req_r,
   input wire logic mem_rd_valid,
   input wire logic [7:0] mem_rd_data,
   output logic mem_wr_req_r,
   input wire logic mem_wr_ack,
   output logic [15:0] mem_addr_r,
   output logic [7:0] mem_wr_data_r,
   input wire logic reg_wr_en,
   input wire logic [3:0] reg_wr_idx,
   input wire logic [7:0] reg_wr_data,
   input wire logic [3:0] reg_rd_idx,
   output logic [7:0] reg_rd_data_r,
   input wire logic ccr_wr_en,
   input wire logic [7:0] ccr_wr_data,
   output logic [7:0] ccr_r
);

   typedef enum logic [2:0] {
      st_idle,
      st_mem_read,
      st_exec,
      st_mem_write
   } alu_state_e;

   alu_state_e state_r;
   alu_state_e state_nxt;
   alu_pkg::alu_req_s cur_r;
   logic [7:0] regs_r [alu_pkg::reg_count];
   logic [7:0] operand_r;

   logic [7:0] dst_val;
   logic [7:0] src_val;
   logic [7:0] ls_result;
   logic ls_carry;
   logic ls_carry_upd;
   logic ls_v;
   logic [7:0] bm_result;
   logic bm_carry;
   logic bm_z;
   logic [2:0] bit_pos;
   logic carry_now;
   logic bad_req;
   logic exec_fire;
   logic reg_result_wr;
   logic [7:0] reg_result;
   logic [7:0] ccr_nxt;

   assign dst_val = regs_r[cur_r.dst_idx];
   // Immediate operand replaces the source register
   assign src_val = cur_r.use_imm ? cur_r.imm : regs_r[cur_r.src_idx];
   // Position from low three bits of a register or from the immediate field
   assign bit_pos = cur_r.pos_from_reg ? regs_r[cur_r.src_idx][2:0] : cur_r.pos_imm;
   assign carry_now = ccr_r[alu_pkg::ccr_c_bit];

   // Register-sourced position is refused for inverted operations; so is memory for non-bit ops
   assign bad_req = (req.pos_from_reg && alu_pkg::imm_pos_only(req.op)) ||
                    (req.mem_operand && !alu_pkg::is_bit_op(req.op));
   assign exec_fire = (state_r == st_exec);

   logic_shift_unit u_logic_shift (
      .op(cur_r.op),
      .a(dst_val),
      .b(src_val),
      .carry_in(carry_now),
      .result(ls_result),
      .carry_out(ls_carry),
      .carry_upd(ls_carry_upd),
      .v_out(ls_v)
   );

   bit_manip_unit u_bit_manip (
      .op(cur_r.op),
      .operand(operand_r),
      .pos(bit_pos),
      .carry_in(carry_now),
      .result(bm_result),
      .carry_out(bm_carry),
      .z_out(bm_z)
   );

   // Sequencing
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         st_idle: begin
            if (req_valid && !bad_req) begin
               state_nxt = req.mem_operand ? st_mem_read : st_exec;
            end
         end
         st_mem_read: begin
            if (mem_rd_valid) begin
               state_nxt = st_exec;
            end
         end
         st_exec: begin
            // Only modifying bit ops on memory need the write-back leg
            if (cur_r.mem_operand && alu_pkg::writes_operand(cur_r.op)) begin
               state_nxt = st_mem_write;
            end else begin
               state_nxt = st_idle;
            end
         end
         st_mem_write: begin
            if (mem_wr_ack) begin
               state_nxt = st_idle;
            end
         end
         default: state_nxt = st_idle;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= st_idle;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cur_r <= '0;
      end else if (state_r == st_idle && req_valid) begin
         cur_r <= req;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         req_ready_r <= 1'b1;
      end else begin
         req_ready_r <= (state_nxt == st_idle);
      end
   end

   // Operand byte: whole memory byte on read, else the destination register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         operand_r <= 8'h00;
      end else if (state_r == st_idle && req_valid) begin
         operand_r <= regs_r[req.dst_idx];
      end else if (state_r == st_mem_read && mem_rd_valid) begin
         operand_r <= mem_rd_data;
      end
   end

   // Memory handshake, request held until answered
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_rd_req_r <= 1'b0;
         mem_wr_req_r <= 1'b0;
         mem_addr_r <= 16'h0000;
         mem_wr_data_r <= 8'h00;
      end else begin
         if (state_r == st_idle && req_valid && !bad_req && req.mem_operand) begin
            mem_rd_req_r <= 1'b1;
            mem_addr_r <= req.mem_addr;
         end else if (mem_rd_valid) begin
            mem_rd_req_r <= 1'b0;
         end
         if (exec_fire && state_nxt == st_mem_write) begin
            mem_wr_req_r <= 1'b1;
            mem_wr_data_r <= bm_result;
         end else if (mem_wr_ack) begin
            mem_wr_req_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         done_r <= 1'b0;
         refused_r <= 1'b0;
      end else begin
         done_r <= (exec_fire && state_nxt == st_idle) || (state_r == st_mem_write && mem_wr_ack);
         refused_r <= (state_r == st_idle) && req_valid && bad_req;
      end
   end

   // Register result selection
   always_comb begin
      reg_result_wr = 1'b0;
      reg_result = ls_result;
      if (exec_fire) begin
         if (!alu_pkg::is_bit_op(cur_r.op)) begin
            reg_result_wr = 1'b1;
            reg_result = ls_result;
         end else if (!cur_r.mem_operand && alu_pkg::writes_operand(cur_r.op)) begin
            reg_result_wr = 1'b1;
            reg_result = bm_result;
         end
      end
   end

   // Core writes lose to a completing result on the same register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < alu_pkg::reg_count; i++) begin
            regs_r[i] <= alu_pkg::reg_reset;
         end
      end else begin
         if (reg_wr_en) begin
            regs_r[reg_wr_idx] <= reg_wr_data;
         end
         if (reg_result_wr) begin
            regs_r[cur_r.dst_idx] <= reg_result;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rd_data_r <= 8'h00;
      end else begin
         reg_rd_data_r <= regs_r[reg_rd_idx];
      end
   end

   // Flag update; probe touches only Z, carry ops only C
   always_comb begin
      ccr_nxt = ccr_r;
      if (exec_fire) begin
         if (!alu_pkg::is_bit_op(cur_r.op)) begin
            ccr_nxt[alu_pkg::ccr_n_bit] = ls_result[7];
            ccr_nxt[alu_pkg::ccr_z_bit] = (ls_result == 8'h00);
            ccr_nxt[alu_pkg::ccr_v_bit] = ls_v;
            if (ls_carry_upd) begin
               ccr_nxt[alu_pkg::ccr_c_bit] = ls_carry;
            end
         end else if (cur_r.op == alu_pkg::bit_probe) begin
            ccr_nxt[alu_pkg::ccr_z_bit] = bm_z;
         end else if (!alu_pkg::writes_operand(cur_r.op)) begin
            ccr_nxt[alu_pkg::ccr_c_bit] = bm_carry;
         end
      end
   end

   // Datapath update wins over a core write in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ccr_r <= alu_pkg::ccr_reset;
      end else if (exec_fire) begin
         ccr_r <= ccr_nxt;
      end else if (ccr_wr_en) begin
         ccr_r <= ccr_wr_data;
      end
   end

endmodule // byte_alu_top

// ==== common/alu_pkg.sv ====
// Shared types, constants and decode helpers for the byte logic, shift and bit datapath
// What this block does
// - AND destination with register or immediate byte
// - OR destination with register or immediate byte
// - XOR destination with register or immediate byte
// - Complement: invert every bit of register
// - Arithmetic shift left and right, written back
// - Logical shift left and right, written back
// - Rotate left or right, bit re-enters opposite
// - Rotate through carry, carry gets shifted-out bit
// - Logic, shift, rotate are byte-only operations
// - Bit set forces chosen bit to one
// - Bit clear forces chosen bit to zero
// - Bit toggle inverts chosen bit, writes back
// - Bit probe: zero flag gets inverted bit
// - Bit position from immediate or register low bits
// - Carry AND/OR/XOR with chosen bit
// - Carry AND/OR/XOR with inverted chosen bit
// - Inverted carry/load/store ops: immediate position only
// - Bit load copies chosen bit into carry
// - Inverted bit load puts complement into carry
// - Bit store writes carry into chosen bit
// - Inverted bit store writes complemented carry
// - Carry and zero held in condition code register
package alu_pkg;

   localparam int unsigned data_w = 8;
   localparam int unsigned reg_count = 16;
   localparam int unsigned reg_idx_w = 4;
   localparam int unsigned addr_w = 16;
   localparam int unsigned pos_w = 3;

   // Condition code register layout
   localparam int unsigned ccr_c_bit = 0;
   localparam int unsigned ccr_v_bit = 1;
   localparam int unsigned ccr_z_bit = 2;
   localparam int unsigned ccr_n_bit = 3;
   localparam logic [7:0] ccr_reset = 8'h80;
   localparam logic [7:0] reg_reset = 8'h00;

   typedef enum logic [4:0] {
      op_and, op_or, op_xor, op_not,
      arith_shift_left, arith_shift_right, logic_shift_left, logic_shift_right,
      rotate_left, rotate_right, rotate_left_through_carry, rotate_right_through_carry,
      bit_force_one, bit_force_zero, bit_toggle, bit_probe,
      carry_and_bit, carry_and_inverted_bit, carry_or_bit, carry_or_inverted_bit,
      carry_xor_bit, carry_xor_inverted_bit,
      bit_to_carry, inverted_bit_to_carry, carry_to_bit, inverted_carry_to_bit
   } alu_op_e;

   typedef struct packed {
      alu_op_e op;
      logic [reg_idx_w-1:0] dst_idx;
      logic [reg_idx_w-1:0] src_idx;
      logic use_imm;
      logic [data_w-1:0] imm;
      logic pos_from_reg;
      logic [pos_w-1:0] pos_imm;
      logic mem_operand;
      logic [addr_w-1:0] mem_addr;
   } alu_req_s;

   function automatic logic is_bit_op(input alu_op_e op);
      return op >= bit_force_one;
   endfunction

   function automatic logic writes_operand(input alu_op_e op);
      return op == bit_force_one || op == bit_force_zero || op == bit_toggle ||
             op == carry_to_bit || op == inverted_carry_to_bit;
   endfunction

   function automatic logic imm_pos_only(input alu_op_e op);
      return op == carry_and_inverted_bit || op == carry_or_inverted_bit ||
             op == carry_xor_inverted_bit || op == inverted_bit_to_carry ||
             op == inverted_carry_to_bit;
   endfunction

endpackage

// ==== rtl/logic_shift_unit.sv ====
// Byte-wide logic, shift and rotate operations
module logic_shift_unit (
   input wire alu_pkg::alu_op_e op,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic carry_in,
   output logic [7:0] result,
   output logic carry_out,
   output logic carry_upd,
   output logic v_out
);
   always_comb begin
      result = a;
      carry_out = carry_in;
      carry_upd = 1'b0;
      v_out = 1'b0;
      case (op)
         alu_pkg::op_and: result = a & b;
         alu_pkg::op_or: result = a | b;
         alu_pkg::op_xor: result = a ^ b;
         alu_pkg::op_not: result = ~a;
         alu_pkg::arith_shift_left, alu_pkg::logic_shift_left: begin
            result = {a[6:0], 1'b0};
            carry_out = a[7];
            carry_upd = 1'b1;
            // Sign change on arithmetic left shift is an overflow
            v_out = (op == alu_pkg::arith_shift_left) ? (a[7] ^ a[6]) : 1'b0;
         end
         alu_pkg::arith_shift_right: begin
            result = {a[7], a[7:1]};
            carry_out = a[0];
            carry_upd = 1'b1;
         end
         alu_pkg::logic_shift_right: begin
            result = {1'b0, a[7:1]};
            carry_out = a[0];
            carry_upd = 1'b1;
         end
         alu_pkg::rotate_left: begin
            result = {a[6:0], a[7]};
            carry_out = a[7];
            carry_upd = 1'b1;
         end
         alu_pkg::rotate_right: begin
            result = {a[0], a[7:1]};
            carry_out = a[0];
            carry_upd = 1'b1;
         end
         alu_pkg::rotate_left_through_carry: begin
            result = {a[6:0], carry_in};
            carry_out = a[7];
            carry_upd = 1'b1;
         end
         alu_pkg::rotate_right_through_carry: begin
            result = {carry_in, a[7:1]};
            carry_out = a[0];
            carry_upd = 1'b1;
         end
         default: result = a;
      endcase
   end
endmodule // logic_shift_unit

// ==== rtl/bit_manip_unit.sv ====
// Single-bit set, clear, toggle, probe and carry-bit operations on a byte
module bit_manip_unit (
   input wire alu_pkg::alu_op_e op,
   input wire logic [7:0] operand,
   input wire logic [2:0] pos,
   input wire logic carry_in,
   output logic [7:0] result,
   output logic carry_out,
   output logic z_out
);
   logic sel;

   always_comb begin
      sel = operand[pos];
      result = operand;
      carry_out = carry_in;
      z_out = ~sel;
      case (op)
         alu_pkg::bit_force_one: result[pos] = 1'b1;
         alu_pkg::bit_force_zero: result[pos] = 1'b0;
         alu_pkg::bit_toggle: result[pos] = ~sel;
         alu_pkg::carry_and_bit: carry_out = carry_in & sel;
         alu_pkg::carry_or_bit: carry_out = carry_in | sel;
         alu_pkg::carry_xor_bit: carry_out = carry_in ^ sel;
         alu_pkg::carry_and_inverted_bit: carry_out = carry_in & ~sel;
         alu_pkg::carry_or_inverted_bit: carry_out = carry_in | ~sel;
         alu_pkg::carry_xor_inverted_bit: carry_out = carry_in ^ ~sel;
         alu_pkg::bit_to_carry: carry_out = sel;
         alu_pkg::inverted_bit_to_carry: carry_out = ~sel;
         alu_pkg::carry_to_bit: result[pos] = carry_in;
         alu_pkg::inverted_carry_to_bit: result[pos] = ~carry_in;
         default: result = operand;
      endcase
   end
endmodule // bit_manip_unit

// ==== tb/byte_alu_monitor.sv ====
// Port-level checks for the byte logic, shift and bit datapath
module byte_alu_monitor (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic req_valid,
   input wire alu_pkg::alu_req_s req,
   input wire logic req_ready_r,
   input wire logic done_r,
   input wire logic refused_r,
   input wire logic mem_rd_req_r,
   input wire logic mem_rd_valid,
   input wire logic [7:0] mem_rd_data,
   input wire logic mem_wr_req_r,
   input wire logic mem_wr_ack,
   input wire logic [15:0] mem_addr_r,
   input wire logic [7:0] mem_wr_data_r,
   input wire logic ccr_wr_en,
   input wire logic [7:0] ccr_r
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic take;
   logic bad;
   logic held_wr;
   alu_pkg::alu_req_s held_r;
   logic [7:0] rd_byte_r;
   assign take = req_valid && req_ready_r;
   // Own copy of the refusal terms, so a slip in the design's decode shows
   assign bad = (req.mem_operand && req.op < alu_pkg::bit_force_one) || (req.pos_from_reg && req.op inside
      {alu_pkg::carry_and_inverted_bit, alu_pkg::carry_or_inverted_bit, alu_pkg::carry_xor_inverted_bit,
      alu_pkg::inverted_bit_to_carry, alu_pkg::inverted_carry_to_bit});
   assign held_wr = held_r.op inside {alu_pkg::bit_force_one, alu_pkg::bit_force_zero, alu_pkg::bit_toggle,
      alu_pkg::carry_to_bit, alu_pkg::inverted_carry_to_bit};
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         held_r <= '0;
      else if (take)
         held_r <= req;
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         rd_byte_r <= 8'h00;
      else if (mem_rd_req_r && mem_rd_valid)
         rd_byte_r <= mem_rd_data;
   end
   refuse_pulse_a: assert property (take && bad |=> refused_r ##1 !done_r)
      else $error("refused request did not pulse refusal alone");
   reg_done_a: assert property (take && !bad && !req.mem_operand |=> !req_ready_r ##1 done_r && req_ready_r)
      else $error("register operation did not complete on time");
   mem_start_a: assert property (take && !bad && req.mem_operand |=> mem_rd_req_r && mem_addr_r == held_r.mem_addr)
      else $error("memory read not started at the request address");
   rd_hold_a: assert property (mem_rd_req_r && !mem_rd_valid |=> mem_rd_req_r && $stable(mem_addr_r))
      else $error("memory read request dropped early");
   rd_next_a: assert property (mem_rd_req_r && mem_rd_valid |=> !mem_rd_req_r ##1 mem_wr_req_r == held_wr &&
      done_r == !held_wr)
      else $error("wrong step after memory read data");
   wr_hold_a: assert property (mem_wr_req_r && !mem_wr_ack |=> mem_wr_req_r && $stable(mem_wr_data_r))
      else $error("memory write request not held");
   wr_done_a: assert property (mem_wr_req_r && mem_wr_ack |=> done_r && !mem_wr_req_r)
      else $error("memory write did not finish after acknowledge");
   set_byte_a: assert property ($rose(mem_wr_req_r) && held_r.op == alu_pkg::bit_force_one && !held_r.pos_from_reg
      |-> mem_wr_data_r == (rd_byte_r | (8'h01 << held_r.pos_imm)))
      else $error("bit set wrote a wrong byte");
   probe_c_a: assert property (done_r && held_r.op == alu_pkg::bit_probe && !$past(ccr_wr_en)
      |-> ccr_r[0] == $past(ccr_r[0]))
      else $error("bit probe altered carry");
endmodule // byte_alu_monitor

bind byte_alu_top byte_alu_monitor byte_alu_monitor_inst (.clk, .reset_n, .req_valid, .req, .req_ready_r, .done_r,
   .refused_r, .mem_rd_req_r, .mem_rd_valid, .mem_rd_data, .mem_wr_req_r, .mem_wr_ack, .mem_addr_r, .mem_wr_data_r,
   .ccr_wr_en, .ccr_r);

// ==== tb/tb_top.sv ====
// Self-checking testbench for the byte logic, shift and bit datapath
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, req_ready_r, done_r, refused_r, mem_rd_req_r, mem_wr_req_r;
   logic reset_n = 1'b0, req_valid = 1'b0, mem_rd_valid = 1'b0, mem_wr_ack = 1'b0, reg_wr_en = 1'b0;
   logic ccr_wr_en = 1'b0;
   logic [7:0] mem_rd_data = 8'h00, reg_wr_data = 8'h00, ccr_wr_data = 8'h00;
   logic [3:0] reg_wr_idx = 4'h0, reg_rd_idx = 4'h0;
   logic [7:0] reg_rd_data_r, ccr_r, mem_wr_data_r, m_ccr, mem_byte;
   logic [15:0] mem_addr_r, exp_addr;
   alu_pkg::alu_req_s req = '0;
   logic [7:0] m_regs [16];
   logic [31:0] seed = 32'h00017457;
   int errors = 0, n_checks = 0, stall = 0, rcnt = 0, wcnt = 0;
   byte_alu_top byte_alu_top_inst (.clk, .reset_n, .req_valid, .req, .req_ready_r, .done_r, .refused_r,
      .mem_rd_req_r, .mem_rd_valid, .mem_rd_data, .mem_wr_req_r, .mem_wr_ack, .mem_addr_r, .mem_wr_data_r,
      .reg_wr_en, .reg_wr_idx, .reg_wr_data, .reg_rd_idx, .reg_rd_data_r, .ccr_wr_en, .ccr_wr_data, .ccr_r);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Returns {ccr, result}; V set only by a sign change on arithmetic left shift
   function automatic logic [15:0] model(input alu_pkg::alu_op_e op, input logic [7:0] a, input logic [7:0] b,
      input logic [2:0] p, input logic [7:0] f);
      logic [7:0] r;
      logic c;
      logic x;
      logic v;
      r = a;
      c = f[0];
      x = a[p];
      v = (op == alu_pkg::arith_shift_left) && (a[7] ^ a[6]);
      case (op)
         alu_pkg::op_and: r = a & b;
         alu_pkg::op_or: r = a | b;
         alu_pkg::op_xor: r = a ^ b;
         alu_pkg::op_not: r = ~a;
         alu_pkg::arith_shift_left, alu_pkg::logic_shift_left: {c, r} = {a, 1'b0};
         alu_pkg::arith_shift_right: {r, c} = {a[7], a};
         alu_pkg::logic_shift_right: {r, c} = {1'b0, a};
         alu_pkg::rotate_left: {c, r} = {a[7], a[6:0], a[7]};
         alu_pkg::rotate_right: {r, c} = {a[0], a};
         alu_pkg::rotate_left_through_carry: {c, r} = {a, f[0]};
         alu_pkg::rotate_right_through_carry: {r, c} = {f[0], a};
         alu_pkg::bit_force_one: r[p] = 1'b1;
         alu_pkg::bit_force_zero: r[p] = 1'b0;
         alu_pkg::bit_toggle: r[p] = ~x;
         alu_pkg::carry_and_bit: c = f[0] & x;
         alu_pkg::carry_and_inverted_bit: c = f[0] & ~x;
         alu_pkg::carry_or_bit: c = f[0] | x;
         alu_pkg::carry_or_inverted_bit: c = f[0] | ~x;
         alu_pkg::carry_xor_bit: c = f[0] ^ x;
         alu_pkg::carry_xor_inverted_bit: c = f[0] ^ ~x;
         alu_pkg::bit_to_carry: c = x;
         alu_pkg::inverted_bit_to_carry: c = ~x;
         alu_pkg::carry_to_bit: r[p] = f[0];
         alu_pkg::inverted_carry_to_bit: r[p] = ~f[0];
         default: ;
      endcase
      if (op < alu_pkg::bit_force_one)
         return {f[7:4], r[7], r == 8'h00, v, c, r};
      if (op == alu_pkg::bit_probe)
         return {f[7:3], ~x, f[1], c, r};
      return {f[7:1], c, r};
   endfunction
   task automatic tick();
      @(posedge clk);
      #2;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Leaves the write strobe up so back-to-back writes never pulse it twice in one step
   task automatic wr_reg(input logic [3:0] i, input logic [7:0] d);
      reg_wr_en = 1'b1;
      reg_wr_idx = i;
      reg_wr_data = d;
      m_regs[i] = d;
      tick();
   endtask
   task automatic rd_chk(input logic [3:0] i, input logic [7:0] exp);
      reg_rd_idx = i;
      tick();
      chk("register", exp, reg_rd_data_r);
   endtask
   task automatic run_op(input alu_pkg::alu_req_s r, input logic refuse);
      int n;
      n = 0;
      req = r;
      req_valid = 1'b1;
      tick();
      req_valid = 1'b0;
      while (done_r !== 1'b1 && refused_r !== 1'b1 && n < 60) begin
         tick();
         n++;
      end
      chk("finished", 8'h01, {7'h00, done_r | refused_r});
      chk("refused", {7'h00, refuse}, {7'h00, refused_r});
   endtask
   // Memory side: answers after a set stall, released data lines show the inverse
   always @(posedge clk) begin
      #2;
      if (mem_rd_valid) begin
         mem_rd_valid = 1'b0;
         mem_rd_data = ~mem_rd_data;
      end else if (mem_rd_req_r === 1'b1) begin
         chk("address high", exp_addr[15:8], mem_addr_r[15:8]);
         chk("address low", exp_addr[7:0], mem_addr_r[7:0]);
         if (rcnt >= stall) begin
            mem_rd_valid = 1'b1;
            mem_rd_data = mem_byte;
            rcnt = 0;
         end else
            rcnt++;
      end
      if (mem_wr_ack)
         mem_wr_ack = 1'b0;
      else if (mem_wr_req_r === 1'b1) begin
         chk("write address", exp_addr[7:0], mem_addr_r[7:0]);
         if (wcnt >= stall) begin
            mem_wr_ack = 1'b1;
            mem_byte = mem_wr_data_r;
            wcnt = 0;
         end else
            wcnt++;
      end
   end
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      give_verdict();
   end
   initial begin
      alu_pkg::alu_req_s r;
      alu_pkg::alu_op_e ref_ops [6];
      logic [15:0] e;
      logic [7:0] a;
      logic [2:0] p;
      ref_ops = '{alu_pkg::carry_and_inverted_bit, alu_pkg::carry_or_inverted_bit, alu_pkg::carry_xor_inverted_bit,
         alu_pkg::inverted_bit_to_carry, alu_pkg::inverted_carry_to_bit, alu_pkg::rotate_left};
      repeat (12) @(posedge clk);
      #2;
      reset_n = 1'b1;
      m_ccr = 8'h80;
      // Register file resets to zero; the model must start there too
      foreach (m_regs[k]) m_regs[k] = 8'h00;
      chk("ccr reset", 8'h80, ccr_r);
      chk("ready", 8'h01, {7'h00, req_ready_r});
      for (int i = 0; i < 16; i++)
         rd_chk(4'(i), 8'h00);
      $display("test reset values done");
      // First two op sweeps use corner bytes 81 and 40, the rest are random
      for (int i = 0; i < 208; i++) begin
         seed = lfsr(seed);
         r = '0;
         r.op = alu_pkg::alu_op_e'(5'(i % 26));
         r.dst_idx = seed[3:0];
         r.src_idx = seed[7:4];
         r.use_imm = seed[8];
         r.imm = seed[23:16];
         r.pos_from_reg = seed[9] && !alu_pkg::imm_pos_only(r.op);
         r.pos_imm = seed[12:10];
         a = (i < 26) ? 8'h81 : (i < 52) ? 8'h40 : seed[31:24];
         ccr_wr_en = 1'b1;
         ccr_wr_data = seed[20:13];
         wr_reg(r.dst_idx, a);
         reg_wr_en = 1'b0;
         ccr_wr_en = 1'b0;
         m_ccr = ccr_wr_data;
         p = r.pos_from_reg ? m_regs[r.src_idx][2:0] : r.pos_imm;
         e = model(r.op, m_regs[r.dst_idx], r.use_imm ? r.imm : m_regs[r.src_idx], p, m_ccr);
         run_op(r, 1'b0);
         chk("ccr", e[15:8], ccr_r);
         rd_chk(r.dst_idx, e[7:0]);
         m_regs[r.dst_idx] = e[7:0];
         m_ccr = e[15:8];
      end
      $display("test register operations done");
      foreach (ref_ops[k]) begin
         r = '0;
         r.op = ref_ops[k];
         r.pos_from_reg = (k < 5);
         r.mem_operand = (k == 5);
         r.dst_idx = 4'h3;
         run_op(r, 1'b1);
         rd_chk(4'h3, m_regs[3]);
         chk("ccr kept", m_ccr, ccr_r);
      end
      $display("test refusals done");
      for (int i = 0; i < 28; i++) begin
         seed = lfsr(seed);
         r = '0;
         r.op = alu_pkg::alu_op_e'(5'(12 + i % 14));
         r.mem_operand = 1'b1;
         r.mem_addr = seed[31:16];
         r.pos_imm = seed[2:0];
         r.src_idx = seed[7:4];
         r.pos_from_reg = seed[3] && !alu_pkg::imm_pos_only(r.op);
         p = r.pos_from_reg ? m_regs[r.src_idx][2:0] : r.pos_imm;
         stall = i % 4;
         mem_byte = seed[15:8];
         exp_addr = r.mem_addr;
         e = model(r.op, mem_byte, 8'h00, p, m_ccr);
         run_op(r, 1'b0);
         chk("memory byte", e[7:0], mem_byte);
         chk("ccr memory", e[15:8], ccr_r);
         m_ccr = e[15:8];
      end
      $display("test memory bit operations done");
      stall = 50;
      r.op = alu_pkg::bit_toggle;
      exp_addr = r.mem_addr;
      req = r;
      req_valid = 1'b1;
      tick();
      req_valid = 1'b0;
      repeat (3) tick();
      reset_n = 1'b0;
      tick();
      chk("ready in reset", 8'h01, {7'h00, req_ready_r});
      chk("read request in reset", 8'h00, {7'h00, mem_rd_req_r});
      reset_n = 1'b1;
      rcnt = 0;
      stall = 0;
      chk("ccr after reset", 8'h80, ccr_r);
      r = '0;
      r.op = alu_pkg::op_not;
      r.dst_idx = 4'h5;
      run_op(r, 1'b0);
      rd_chk(4'h5, 8'hff);
      chk("ccr after complement", 8'h88, ccr_r);
      $display("test reset during operation done");
      give_verdict();
   end
endmodule // tb_top
